// File: common/ctlr_consts.svh
// constants for the top-level cpu interface control fields
// Behaviour
// - bit 4: eoi mode, non-secure kernel/hypervisor
// - bit 3: eoi mode, secure kernel/hypervisor
// - bit 2: eoi mode, most privileged level
// - mode zero: eoi drops and deactivates
// - mode one: eoi drops only, deactivate register deactivates
// - kernel copies alias eoi mode bits 4, 3
// - bit 1 clear: separate non-secure group1 binary point
// - bit 1 set: group0 binary point shared
// - bit 0 clear: separate secure group1 binary point
// - bit 0 set: group0 binary point shared
// - kernel copies alias binary point bits 1, 0
// - reset clears all fields to zero
// - access via fixed system register encoding
// - lower privilege access is undefined
// - top level: trap when disabled, else access
`ifndef CTLR_CONSTS_SVH
`define CTLR_CONSTS_SVH
`define EOI_NS_BIT 4
`define EOI_S_BIT 3
`define EOI_TOP_BIT 2
`define BINPOINT_NS_BIT 1
`define BINPOINT_S_BIT 0
`define FIELD_W 5
`define FIELDS_RESET 5'h00
`define ENC_OP0 2'h3
`define ENC_OP1 3'h6
`define ENC_CRN 4'hc
`define ENC_CRM 4'hc
`define ENC_OP2 3'h4
`define LEVEL_TOP 2'h3
`define TRAP_CLASS 6'h18
`define CTX_NS 2'h0
`define CTX_S 2'h1
`endif

// File: common/ctlr_pkg.sv
// types for the top-level cpu interface control block
`default_nettype none
package ctlr_pkg;
  typedef struct packed {
    logic [4:0] fields;
    logic programmed;
    logic rsp_valid;
    logic rsp_undef;
    logic rsp_trap;
    logic [5:0] rsp_class;
    logic [63:0] rsp_rdata;
    logic prio_drop;
    logic deact;
    logic dir_unpred;
  } ctl_state_t;
endpackage
`default_nettype wire

// File: hdl/sysreg_access_decode.sv
// decode of a system register access against the control register
`timescale 1ns/10ps
`default_nettype none
`include "ctlr_consts.svh"
module sysreg_access_decode (
  input wire logic valid,
  input wire logic [1:0] op0,
  input wire logic [2:0] op1,
  input wire logic [3:0] crn,
  input wire logic [3:0] crm,
  input wire logic [2:0] op2,
  input wire logic [1:0] level,
  input wire logic sysreg_en,
  output logic hit,
  output logic undef,
  output logic trap,
  output logic ok
);
  always_comb begin
    hit = valid && op0 == `ENC_OP0 && op1 == `ENC_OP1 && crn == `ENC_CRN
      && crm == `ENC_CRM && op2 == `ENC_OP2;
    undef = hit && level != `LEVEL_TOP;
    trap = hit && level == `LEVEL_TOP && !sysreg_en;
    ok = hit && level == `LEVEL_TOP && sysreg_en;
  end
endmodule
`default_nettype wire

// File: hdl/cpu_if_eoi_binpoint_ctrl.sv
// eoi mode and common binary point control fields with system register access
`timescale 1ns/10ps
`default_nettype none
`include "ctlr_consts.svh"
module cpu_if_eoi_binpoint_ctrl
  import ctlr_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_OP0,
  input wire logic [2:0] REQ_OP1,
  input wire logic [3:0] REQ_CRN,
  input wire logic [3:0] REQ_CRM,
  input wire logic [2:0] REQ_OP2,
  input wire logic [1:0] REQ_LEVEL,
  input wire logic [63:0] REQ_WDATA,
  input wire logic SYSREG_ENABLE,
  input wire logic [58:0] UPPER_FIELDS,
  output logic RSP_VALID,
  output logic RSP_UNDEF,
  output logic RSP_TRAP,
  output logic [5:0] RSP_CLASS,
  output logic [63:0] RSP_RDATA,
  input wire logic KCTL_WR,
  input wire logic KCTL_SECURE,
  input wire logic KCTL_EOI_MODE,
  input wire logic KCTL_COMMON_BINPOINT,
  input wire logic EOI_WR,
  input wire logic DIR_WR,
  input wire logic [1:0] EOI_CTX,
  output logic PRIO_DROP,
  output logic DEACTIVATE,
  output logic DIR_UNPREDICTABLE,
  input wire logic BPR1_ACC,
  input wire logic BPR1_SECURE,
  output logic BPR1_TO_BPR0,
  output logic EOI_MODE_NS,
  output logic EOI_MODE_S,
  output logic EOI_MODE_TOP,
  output logic COMMON_BINPOINT_NS,
  output logic COMMON_BINPOINT_S,
  output logic CFG_PROGRAMMED
);
  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic hit;
  logic undef;
  logic trap;
  logic ok;
  logic mode_sel;

  sysreg_access_decode sysreg_access_decode_i (
    .valid(REQ_VALID),
    .op0(REQ_OP0),
    .op1(REQ_OP1),
    .crn(REQ_CRN),
    .crm(REQ_CRM),
    .op2(REQ_OP2),
    .level(REQ_LEVEL),
    .sysreg_en(SYSREG_ENABLE),
    .hit(hit),
    .undef(undef),
    .trap(trap),
    .ok(ok)
  );

  // eoi mode of the handling context
  always_comb begin
    unique case (EOI_CTX)
      `CTX_NS: mode_sel = st_r.fields[`EOI_NS_BIT];
      `CTX_S: mode_sel = st_r.fields[`EOI_S_BIT];
      default: mode_sel = st_r.fields[`EOI_TOP_BIT];
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = hit;
    st_nxt.rsp_undef = undef;
    st_nxt.rsp_trap = trap;
    st_nxt.rsp_class = trap ? `TRAP_CLASS : 6'h00;
    st_nxt.rsp_rdata = 64'h0;
    // kernel copies write the aliased bits
    if (KCTL_WR) begin
      if (KCTL_SECURE) begin
        st_nxt.fields[`EOI_S_BIT] = KCTL_EOI_MODE;
        st_nxt.fields[`BINPOINT_S_BIT] = KCTL_COMMON_BINPOINT;
      end else begin
        st_nxt.fields[`EOI_NS_BIT] = KCTL_EOI_MODE;
        st_nxt.fields[`BINPOINT_NS_BIT] = KCTL_COMMON_BINPOINT;
      end
      st_nxt.programmed = 1'b1;
    end
    if (ok && REQ_WRITE) begin
      st_nxt.fields = REQ_WDATA[`FIELD_W-1:0];
      st_nxt.programmed = 1'b1;
    end
    if (ok && !REQ_WRITE) begin
      st_nxt.rsp_rdata = {UPPER_FIELDS, st_r.fields};
    end
    st_nxt.prio_drop = EOI_WR;
    st_nxt.deact = (EOI_WR && !mode_sel) || (DIR_WR && mode_sel);
    st_nxt.dir_unpred = DIR_WR && !mode_sel;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r <= '0;
      st_r.fields <= `FIELDS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    RSP_VALID = st_r.rsp_valid;
    RSP_UNDEF = st_r.rsp_undef;
    RSP_TRAP = st_r.rsp_trap;
    RSP_CLASS = st_r.rsp_class;
    RSP_RDATA = st_r.rsp_rdata;
    PRIO_DROP = st_r.prio_drop;
    DEACTIVATE = st_r.deact;
    DIR_UNPREDICTABLE = st_r.dir_unpred;
    EOI_MODE_NS = st_r.fields[`EOI_NS_BIT];
    EOI_MODE_S = st_r.fields[`EOI_S_BIT];
    EOI_MODE_TOP = st_r.fields[`EOI_TOP_BIT];
    COMMON_BINPOINT_NS = st_r.fields[`BINPOINT_NS_BIT];
    COMMON_BINPOINT_S = st_r.fields[`BINPOINT_S_BIT];
    // group1 binary point access lands on group0 state when the context's common binary point bit is set
    BPR1_TO_BPR0 = BPR1_ACC && (BPR1_SECURE ? st_r.fields[`BINPOINT_S_BIT]
      : st_r.fields[`BINPOINT_NS_BIT]);
    CFG_PROGRAMMED = st_r.programmed;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  property p_eoi_full;
    EOI_WR && !mode_sel && !DIR_WR |=> PRIO_DROP && DEACTIVATE && !DIR_UNPREDICTABLE;
  endproperty
  a_eoi_full: assert property (p_eoi_full) else $error("eoi mode 0 must deactivate");

  property p_eoi_drop_only;
    EOI_WR && mode_sel && !DIR_WR |=> PRIO_DROP && !DEACTIVATE;
  endproperty
  a_eoi_drop_only: assert property (p_eoi_drop_only) else $error("eoi mode 1 drop only");

  property p_dir_deact;
    DIR_WR && mode_sel |=> DEACTIVATE && !DIR_UNPREDICTABLE;
  endproperty
  a_dir_deact: assert property (p_dir_deact) else $error("dir must deactivate");

  property p_dir_unpred;
    DIR_WR && !mode_sel && !EOI_WR |=> DIR_UNPREDICTABLE && !DEACTIVATE;
  endproperty
  a_dir_unpred: assert property (p_dir_unpred) else $error("dir in mode 0 flagged");

  property p_undef;
    REQ_VALID && hit && REQ_LEVEL != `LEVEL_TOP
      |=> RSP_VALID && RSP_UNDEF && !RSP_TRAP && RSP_RDATA == 64'h0;
  endproperty
  a_undef: assert property (p_undef) else $error("lower level access not undefined");

  property p_trap;
    hit && REQ_LEVEL == `LEVEL_TOP && !SYSREG_ENABLE && !KCTL_WR
      |=> RSP_TRAP && RSP_CLASS == `TRAP_CLASS && $stable(st_r.fields);
  endproperty
  a_trap: assert property (p_trap) else $error("disabled access did not trap");

  property p_write;
    ok && REQ_WRITE |=> {EOI_MODE_NS, EOI_MODE_S, EOI_MODE_TOP, COMMON_BINPOINT_NS,
      COMMON_BINPOINT_S} == $past(REQ_WDATA[`FIELD_W-1:0]) && CFG_PROGRAMMED;
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_read;
    ok && !REQ_WRITE |=> RSP_RDATA == {$past(UPPER_FIELDS), $past(st_r.fields)};
  endproperty
  a_read: assert property (p_read) else $error("read value wrong");

  property p_alias_ns;
    KCTL_WR && !KCTL_SECURE && !(ok && REQ_WRITE)
      |=> EOI_MODE_NS == $past(KCTL_EOI_MODE)
      && COMMON_BINPOINT_NS == $past(KCTL_COMMON_BINPOINT);
  endproperty
  a_alias_ns: assert property (p_alias_ns) else $error("ns alias not written");

  property p_alias_s;
    KCTL_WR && KCTL_SECURE && !(ok && REQ_WRITE)
      |=> EOI_MODE_S == $past(KCTL_EOI_MODE)
      && COMMON_BINPOINT_S == $past(KCTL_COMMON_BINPOINT);
  endproperty
  a_alias_s: assert property (p_alias_s) else $error("s alias not written");

  property p_bpr_ns;
    BPR1_ACC && !BPR1_SECURE |-> BPR1_TO_BPR0 == COMMON_BINPOINT_NS;
  endproperty
  a_bpr_ns: assert property (p_bpr_ns) else $error("ns bpr redirect wrong");

  property p_bpr_s;
    BPR1_ACC && BPR1_SECURE |-> BPR1_TO_BPR0 == COMMON_BINPOINT_S;
  endproperty
  a_bpr_s: assert property (p_bpr_s) else $error("s bpr redirect wrong");

  property p_bpr_separate;
    !BPR1_ACC || (BPR1_SECURE ? !COMMON_BINPOINT_S : !COMMON_BINPOINT_NS) |-> !BPR1_TO_BPR0;
  endproperty
  a_bpr_separate: assert property (p_bpr_separate) else $error("bpr redirect unshared");

  c_trap: cover property (hit && REQ_LEVEL == `LEVEL_TOP && !SYSREG_ENABLE ##1 RSP_TRAP);
  c_write_read: cover property (ok && REQ_WRITE ##1 ok && !REQ_WRITE ##1 RSP_VALID);
  c_dir_mode1: cover property (DIR_WR && mode_sel ##1 DEACTIVATE);
  c_bpr_share: cover property (BPR1_TO_BPR0);
endmodule
`default_nettype wire

// File: tb/core_req_model.sv
// processor core model issuing system register instructions
`timescale 1ns/10ps
`default_nettype none
`include "ctlr_consts.svh"
module core_req_model (
  output logic valid,
  output logic write,
  output logic [1:0] op0,
  output logic [2:0] op1,
  output logic [3:0] crn,
  output logic [3:0] crm,
  output logic [2:0] op2,
  output logic [1:0] level,
  output logic [63:0] wdata
);
  initial {valid, write, op0, op1, crn, crm, op2, level, wdata} = '0;
  // one request per call, idle lines show the inverse of their last value
  task automatic issue(input logic go, input logic wr, input logic bad, input logic [1:0] lvl,
    input logic [63:0] d);
    if (go) begin
      {op0, op1, crn, crm, op2} = {`ENC_OP0, `ENC_OP1, `ENC_CRN, `ENC_CRM, `ENC_OP2};
      if (bad) op2 = ~op2;
      {valid, write, level, wdata} = {1'b1, wr, lvl, d};
    end else begin
      valid = 1'b0;
      {write, op0, op1, crn, crm, op2, level, wdata} = ~{write, op0, op1, crn, crm, op2, level, wdata};
    end
  endtask
endmodule
`default_nettype wire

// File: tb/cpu_if_eoi_binpoint_ctrl_bench.sv
// self-checking bench for the eoi mode and binary point control block
`timescale 1ns/10ps
`default_nettype none
module cpu_if_eoi_binpoint_ctrl_bench;
  logic mclk, rst_n, sys_en, kwr, ksec, keoi, kcbp, eoi, dir, bacc, bsec, md, pg, go, bad, wr;
  logic hit, ok;
  logic [1:0] ctx, lvl, op0, level;
  logic [2:0] op1, op2, eio;
  logic [3:0] crn, crm;
  logic [4:0] f;
  logic [8:0] ersp;
  logic [31:0] r;
  logic [58:0] upper;
  logic [63:0] wd, wdata, edat;
  logic valid, write;
  wire logic rv, ru, rt, pd, dv, du, b2b, prog;
  wire logic [5:0] rcls;
  wire logic [63:0] rdat;
  wire logic [4:0] fo;
  int fails, check_count;
  int seed = 19259;
  core_req_model core_req_model_i (.valid(valid), .write(write), .op0(op0), .op1(op1),
    .crn(crn), .crm(crm), .op2(op2), .level(level), .wdata(wdata));
  cpu_if_eoi_binpoint_ctrl cpu_if_eoi_binpoint_ctrl_i (.MCLK(mclk), .RST_N(rst_n),
    .REQ_VALID(valid), .REQ_WRITE(write), .REQ_OP0(op0), .REQ_OP1(op1), .REQ_CRN(crn),
    .REQ_CRM(crm), .REQ_OP2(op2), .REQ_LEVEL(level), .REQ_WDATA(wdata), .SYSREG_ENABLE(sys_en),
    .UPPER_FIELDS(upper), .RSP_VALID(rv), .RSP_UNDEF(ru), .RSP_TRAP(rt), .RSP_CLASS(rcls),
    .RSP_RDATA(rdat), .KCTL_WR(kwr), .KCTL_SECURE(ksec), .KCTL_EOI_MODE(keoi),
    .KCTL_COMMON_BINPOINT(kcbp), .EOI_WR(eoi), .DIR_WR(dir), .EOI_CTX(ctx), .PRIO_DROP(pd),
    .DEACTIVATE(dv), .DIR_UNPREDICTABLE(du), .BPR1_ACC(bacc), .BPR1_SECURE(bsec),
    .BPR1_TO_BPR0(b2b), .EOI_MODE_NS(fo[4]), .EOI_MODE_S(fo[3]), .EOI_MODE_TOP(fo[2]),
    .COMMON_BINPOINT_NS(fo[1]), .COMMON_BINPOINT_S(fo[0]), .CFG_PROGRAMMED(prog));
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    {rst_n, sys_en, kwr, ksec, keoi, kcbp, eoi, dir, bacc, bsec, ctx, upper} = '0;
    {f, pg, ersp, edat, eio} = '0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    for (int t = 0; t < 3; t++) begin
      if (t == 2) begin
        @(negedge mclk);
        rst_n = 1'b0;
        core_req_model_i.issue(1'b0, 1'b0, 1'b0, 2'h0, 64'h0);
        {kwr, eoi, dir, bacc} = '0;
        @(negedge mclk);
        rst_n = 1'b1;
        {f, pg, ersp, edat, eio} = '0;
      end
      for (int n = 0; n < 200; n++) begin
        @(negedge mclk);
        check("response", {rv, ru, rt, rcls}, ersp);
        check("read_data", rdat, edat);
        check("fields", {fo, prog}, {f, pg});
        check("eoi_outputs", {pd, dv, du}, eio);
        r = $random(seed);
        wd = {$random(seed), $random(seed)};
        {go, wr, bad} = {r[0] | r[1], r[2], t > 0 && r[5:3] == 3'h0};
        lvl = (t == 0) ? 2'h3 : r[7:6] | {2{r[8]}};
        sys_en = t == 0 || r[9] || r[10];
        {kwr, ksec, keoi, kcbp, eoi, dir, ctx, bacc, bsec} = r[20:11];
        upper = {$random(seed), r[26:0]};
        core_req_model_i.issue(go, wr, bad, lvl, wd);
        #1;
        check("bpr_redirect", b2b, bacc & (bsec ? f[0] : f[1]));
        hit = go && !bad;
        ok = hit && lvl == 2'h3 && sys_en;
        ersp = {hit, hit && lvl != 2'h3, hit && lvl == 2'h3 && !sys_en, 6'h0};
        if (ersp[6])
          ersp[5:0] = `TRAP_CLASS;
        edat = (ok && !wr) ? {upper, f} : 64'h0;
        md = (ctx == 2'h0) ? f[4] : (ctx == 2'h1) ? f[3] : f[2];
        eio = {eoi, (eoi & !md) | (dir & md), dir & !md};
        pg = pg | (ok && wr) | kwr;
        if (ok && wr)
          f = wd[4:0];
        else if (kwr && ksec)
          {f[3], f[0]} = {keoi, kcbp};
        else if (kwr)
          {f[4], f[1]} = {keoi, kcbp};
      end
      $display("test %0d finished", t);
    end
    complete_run();
  end
endmodule
`default_nettype wire
